// File: clock_and_power_mode_control.sv
// Clock source, brown-out and low-power mode controller of a dual-core chip.
// Assumes all inputs synchronous to CLK and software keeping its own switching duties.
`timescale 1ns/10ps
`include "pm_map.svh"
module clock_and_power_mode_control
  import pm_pkg::*;
#(
  parameter int NB = 4,
  parameter logic [27:0] XTAL_HZ = 28'h0f42400,
  parameter int RESTORE_CYC = `PM_RESTORE_CYC
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic ENTER_REQ,
  input wire pm_mode_t MODE_REQ,
  input wire logic [`PM_NUM_PERIPH-1:0] PERIPH_KEEP,
  input wire logic [`PM_NUM_PERIPH-1:0] WAKE_EN,
  input wire logic [`PM_NUM_PERIPH-1:0] WAKE_EVT,
  input wire logic [3:0] WAKE_PIN,
  input wire logic ONE_HZ_ALARM_FLAG,
  input wire logic OSTIMER_DPD_EN,
  input wire logic [NB-1:0] SRAM_RET_CFG,
  input wire logic OSC12_RUN,
  input wire logic OSC96_RUN,
  input wire logic XTAL_RUN,
  input wire logic LP1M_RUN,
  input wire logic RTC_OSC_CONTROL_REG,
  input wire pll_cfg_t PLL_A_CFG,
  input wire pll_cfg_t PLL_B_CFG,
  input wire logic [2:0] MAIN_SEL_REQ,
  input wire logic [2:0] MON_SEL_REQ,
  input wire logic [4:0] VBAT_LEVEL,
  input wire bod_cfg_t BOD_CFG,
  input wire logic BOD_IRQ_CLR,
  output logic PLL_A_OUTPUT_RUN,
  output logic PLL_B_OUTPUT_RUN,
  output logic PLL_A_CFG_ERR,
  output logic PLL_B_CFG_ERR,
  output logic [2:0] MAIN_CLK_SEL,
  output logic MAIN_SW_BLOCKED,
  output logic [2:0] CLOCK_MONITOR_OUT_SEL,
  output logic CLOCK_MONITOR_DIV_RUN,
  output logic BROWNOUT_DETECTOR_IRQ,
  output logic CHIP_RESET_REQ,
  output pwr_ctrl_t PWR_CTRL,
  output logic [`PM_NUM_PERIPH-1:0] PERIPH_CLK_EN,
  output logic [NB-1:0] SRAM_BANK_RET,
  output logic [6:0] REG_RETAIN,
  output logic [4:0] DOMAIN_PWR,
  output pm_state_t MODE_STATE
);

  localparam int NP = `PM_NUM_PERIPH;
  localparam int RESTORE_MIN = RESTORE_CYC;
  localparam int RESTORE_MAX = RESTORE_CYC + 1;

  // ****************************************************************
  // Shared arithmetic
  // ****************************************************************
  // Frequency of the chosen PLL reference.
  function automatic logic [27:0] ref_hz(input logic [1:0] sel);
    logic [27:0] f;
    f = `PM_OSC12_HZ;
    case (sel)
      `PM_REF_OSC12: f = `PM_OSC12_HZ;
      `PM_REF_XTAL: f = XTAL_HZ;
      `PM_REF_LP1M: f = `PM_LP1M_HZ;
      `PM_REF_RTC32K: f = `PM_RTC32K_HZ;
      default: f = `PM_OSC12_HZ;
    endcase
    return f;
  endfunction : ref_hz

  // Whether the chosen reference is actually running.
  function automatic logic ref_up(input logic [1:0] sel);
    logic r;
    r = OSC12_RUN;
    case (sel)
      `PM_REF_OSC12: r = OSC12_RUN;
      `PM_REF_XTAL: r = XTAL_RUN;
      `PM_REF_LP1M: r = LP1M_RUN;
      `PM_REF_RTC32K: r = RTC_OSC_CONTROL_REG;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : ref_up

  // Reference inside the input window and product inside the output window.
  function automatic logic pll_cfg_ok(input pll_cfg_t cfg);
    logic [27:0] fin;
    logic [39:0] fout;
    fin = ref_hz(cfg.ref_sel);
    fout = {12'h000, fin} * {28'h0000000, cfg.mult};
    return (fin >= `PM_PLL_IN_MIN_HZ) && (fin <= `PM_PLL_IN_MAX_HZ)
      && (fout >= `PM_PLL_OUT_MIN_HZ) && (fout <= `PM_PLL_OUT_MAX_HZ);
  endfunction : pll_cfg_ok

  // ****************************************************************
  // PLL enables
  // ****************************************************************
  logic pll_a_ok;
  logic pll_b_ok;

  // A PLL only runs when enabled, its reference toggles and both windows hold.
  assign pll_a_ok = pll_cfg_ok(PLL_A_CFG);
  assign pll_b_ok = pll_cfg_ok(PLL_B_CFG);

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      PLL_A_OUTPUT_RUN <= 1'b0;
      PLL_B_OUTPUT_RUN <= 1'b0;
      PLL_A_CFG_ERR <= 1'b0;
      PLL_B_CFG_ERR <= 1'b0;
    end
    else
    begin
      PLL_A_OUTPUT_RUN <= PLL_A_CFG.en & ref_up(PLL_A_CFG.ref_sel) & pll_a_ok;
      PLL_B_OUTPUT_RUN <= PLL_B_CFG.en & ref_up(PLL_B_CFG.ref_sel) & pll_b_ok;
      PLL_A_CFG_ERR <= PLL_A_CFG.en & ~pll_a_ok;
      PLL_B_CFG_ERR <= PLL_B_CFG.en & ~pll_b_ok;
    end
  end

  // ****************************************************************
  // Clock multiplexers
  // ****************************************************************
  logic [7:0] src_run;

  // Code 0 is the tied-off none input, which software picks for an idle mux.
  assign src_run = {PLL_B_OUTPUT_RUN, PLL_A_OUTPUT_RUN,
    RTC_OSC_CONTROL_REG, LP1M_RUN, XTAL_RUN, OSC96_RUN, OSC12_RUN, 1'b1};

  clk_switch #(
    .SW(3),
    .SYNC(1'b1),
    .HALT_CYC(`PM_HALT_CYC)
  ) u_main_switch (
    .clk(CLK),
    .reset(RESET),
    .req_sel(MAIN_SEL_REQ),
    .src_run(src_run),
    .cur_sel(MAIN_CLK_SEL),
    .div_run(),
    .blocked(MAIN_SW_BLOCKED)
  );

  clk_switch #(
    .SW(3),
    .SYNC(1'b0),
    .HALT_CYC(`PM_HALT_CYC)
  ) u_mon_switch (
    .clk(CLK),
    .reset(RESET),
    .req_sel(MON_SEL_REQ),
    .src_run(src_run),
    .cur_sel(CLOCK_MONITOR_OUT_SEL),
    .div_run(CLOCK_MONITOR_DIV_RUN),
    .blocked()
  );

  // ****************************************************************
  // Brown-out detector
  // ****************************************************************
  logic bod_below;

  assign bod_below = VBAT_LEVEL < BOD_CFG.thresh;

  // The sticky flag keeps a set that lands in the same cycle as a clear.
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      BROWNOUT_DETECTOR_IRQ <= 1'b0;
      CHIP_RESET_REQ <= 1'b0;
    end
    else
    begin
      if (bod_below && !BOD_CFG.reset_sel)
      begin
        BROWNOUT_DETECTOR_IRQ <= 1'b1;
      end
      else if (BOD_IRQ_CLR)
      begin
        BROWNOUT_DETECTOR_IRQ <= 1'b0;
      end
      CHIP_RESET_REQ <= bod_below & BOD_CFG.reset_sel;
    end
  end

  // ****************************************************************
  // Wake decode
  // ****************************************************************
  logic [NP-1:0] evt_all;
  logic [NP-1:0] dpd_keep;
  logic wake_sleep;
  logic wake_ds;
  logic wake_pd;
  logic wake_dpd;

  // Brown-out and the one-hertz alarm join the peripheral requests.
  assign evt_all = WAKE_EVT | (bod_below ? `PM_MASK_BOD : '0)
    | (ONE_HZ_ALARM_FLAG ? `PM_MASK_RTC : '0);
  assign dpd_keep = `PM_MASK_RTC | (OSTIMER_DPD_EN ? `PM_MASK_OST : '0);
  assign wake_sleep = |(evt_all & WAKE_EN);
  assign wake_ds = |(evt_all & WAKE_EN & `PM_MASK_DS_WAKE);
  assign wake_pd = |(evt_all & WAKE_EN & `PM_MASK_PD_WAKE);
  assign wake_dpd = (|(evt_all & dpd_keep)) | (|WAKE_PIN);

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  pm_state_t state_next;
  logic [15:0] cnt_reg;

  // A wake always passes through the restore state before the cores run.
  always_comb
  begin
    state_next = MODE_STATE;
    case (MODE_STATE)
      ST_ACTIVE:
      begin
        if (ENTER_REQ)
        begin
          case (MODE_REQ)
            MODE_SLEEP: state_next = ST_SLEEP;
            MODE_DSLEEP: state_next = ST_DSLEEP;
            MODE_PDOWN: state_next = ST_PDOWN;
            MODE_DPDOWN: state_next = ST_DPDOWN;
            default: state_next = ST_ACTIVE;
          endcase
        end
      end
      ST_SLEEP: state_next = wake_sleep ? ST_WAKE : ST_SLEEP;
      ST_DSLEEP: state_next = wake_ds ? ST_WAKE : ST_DSLEEP;
      ST_PDOWN: state_next = wake_pd ? ST_WAKE : ST_PDOWN;
      ST_DPDOWN: state_next = wake_dpd ? ST_WAKE : ST_DPDOWN;
      ST_WAKE:
      begin
        if (cnt_reg == 16'(RESTORE_CYC - 1))
        begin
          state_next = ST_ACTIVE;
        end
      end
      default: state_next = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      MODE_STATE <= ST_ACTIVE;
      cnt_reg <= 16'h0000;
    end
    else
    begin
      MODE_STATE <= state_next;
      cnt_reg <= (MODE_STATE == ST_WAKE) ? cnt_reg + 16'h0001 : 16'h0000;
    end
  end

  // ****************************************************************
  // Power, clock and retention outputs
  // ****************************************************************
  // Outputs follow the next state so they line up with MODE_STATE in each cycle.
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      PWR_CTRL <= '{cpu_clk_en: 2'h3, flash_pwr: 1'b1, dcdc_en: 1'b1, default: 1'b0};
      PERIPH_CLK_EN <= `PM_MASK_ALL;
      SRAM_BANK_RET <= '0;
      REG_RETAIN <= `PM_RET_ALL;
      DOMAIN_PWR <= `PM_DOM_ALL;
    end
    else
    begin
      PWR_CTRL.cpu_clk_en <= (state_next == ST_ACTIVE) ? 2'h3 : 2'h0;
      PWR_CTRL.flash_pwr <= !(state_next inside {ST_DSLEEP, ST_PDOWN, ST_DPDOWN});
      PWR_CTRL.dcdc_en <= !(state_next inside {ST_PDOWN, ST_DPDOWN});
      PWR_CTRL.gpio_hold <= state_next == ST_DSLEEP;
      PWR_CTRL.gpio_low <= state_next == ST_PDOWN;
      PWR_CTRL.pin_tristate <= state_next == ST_DPDOWN;
      PWR_CTRL.cpu0_ret <= state_next == ST_PDOWN;
      SRAM_BANK_RET <= (state_next inside {ST_DSLEEP, ST_PDOWN, ST_DPDOWN})
        ? SRAM_RET_CFG : '0;
      case (state_next)
        ST_SLEEP: PERIPH_CLK_EN <= PERIPH_KEEP;
        ST_DSLEEP: PERIPH_CLK_EN <= PERIPH_KEEP & `PM_MASK_DS_KEEP;
        ST_PDOWN: PERIPH_CLK_EN <= PERIPH_KEEP & `PM_MASK_PD_KEEP;
        ST_DPDOWN: PERIPH_CLK_EN <= dpd_keep;
        default: PERIPH_CLK_EN <= `PM_MASK_ALL;
      endcase
      case (state_next)
        ST_PDOWN: REG_RETAIN <= `PM_RET_PDOWN;
        ST_DPDOWN: REG_RETAIN <= `PM_RET_RTC | (OSTIMER_DPD_EN ? `PM_RET_OST : 7'h00);
        default: REG_RETAIN <= `PM_RET_ALL;
      endcase
      DOMAIN_PWR <= (state_next == ST_DPDOWN)
        ? (`PM_DOM_DPD | (OSTIMER_DPD_EN ? `PM_DOM_OST : 5'h00)) : `PM_DOM_ALL;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  cores_gated_a: assert property (@(posedge CLK) disable iff (RESET)
    (MODE_STATE != ST_ACTIVE) |-> PWR_CTRL.cpu_clk_en == 2'h0)
    else $error("core clock running outside active mode");
  flash_off_a: assert property (@(posedge CLK) disable iff (RESET)
    (MODE_STATE inside {ST_DSLEEP, ST_PDOWN}) |-> !PWR_CTRL.flash_pwr
      && (PERIPH_CLK_EN & ~PERIPH_KEEP) == '0)
    else $error("flash or unkept peripheral clock on in deep mode");
  pd_power_a: assert property (@(posedge CLK) disable iff (RESET)
    (MODE_STATE == ST_PDOWN) |-> !PWR_CTRL.dcdc_en
      && (PERIPH_CLK_EN & ~`PM_MASK_PD_KEEP) == '0)
    else $error("power-down left converter or clocks on");
  pd_wake_filter_a: assert property (@(posedge CLK) disable iff (RESET)
    (MODE_STATE == ST_PDOWN && !wake_pd) |=> MODE_STATE == ST_PDOWN)
    else $error("power-down left without an allowed wake source");
  gpio_low_a: assert property (@(posedge CLK) disable iff (RESET)
    PWR_CTRL.gpio_low == (MODE_STATE == ST_PDOWN))
    else $error("gpio low drive out of step with power-down");
  dpd_pins_a: assert property (@(posedge CLK) disable iff (RESET)
    (MODE_STATE == ST_DPDOWN) |-> PWR_CTRL.pin_tristate && DOMAIN_PWR[0] == 1'b0)
    else $error("pins or core powered in deep power-down");
  alarm_wake_a: assert property (@(posedge CLK) disable iff (RESET)
    (MODE_STATE == ST_DPDOWN && ONE_HZ_ALARM_FLAG) |=> MODE_STATE == ST_WAKE)
    else $error("one-hertz alarm did not wake deep power-down");
  wake_restore_a: assert property (@(posedge CLK) disable iff (RESET)
    $rose(MODE_STATE == ST_WAKE) |-> (PWR_CTRL.flash_pwr && PWR_CTRL.dcdc_en
      && PWR_CTRL.cpu_clk_en == 2'h0) ##[RESTORE_MIN:RESTORE_MAX]
      PWR_CTRL.cpu_clk_en == 2'h3)
    else $error("cores released before restore or too late");
  bod_action_a: assert property (@(posedge CLK) disable iff (RESET)
    (bod_below && BOD_CFG.reset_sel) |=> CHIP_RESET_REQ)
    else $error("brown-out reset not raised");
  pll_enable_a: assert property (@(posedge CLK) disable iff (RESET)
    PLL_A_OUTPUT_RUN |-> $past(PLL_A_CFG.en) && $past(pll_a_ok))
    else $error("PLL running while disabled or out of range");

  sleep_cover_c: cover property (@(posedge CLK) disable iff (RESET)
    MODE_STATE == ST_SLEEP ##1 MODE_STATE == ST_WAKE);
  pd_cover_c: cover property (@(posedge CLK) disable iff (RESET)
    MODE_STATE == ST_PDOWN ##1 MODE_STATE == ST_WAKE);
  dpd_cover_c: cover property (@(posedge CLK) disable iff (RESET)
    MODE_STATE == ST_DPDOWN ##1 MODE_STATE == ST_WAKE);
  bod_cover_c: cover property (@(posedge CLK) disable iff (RESET)
    $rose(BROWNOUT_DETECTOR_IRQ));

endmodule : clock_and_power_mode_control

// File: pm_map.svh
// Constants for the clock and power-mode controller: masks, codes, limits and timing.
// Assumes one 20 MHz system clock; included by the package user modules by bare name.
`ifndef PM_MAP_SVH
`define PM_MAP_SVH

// ****************************************************************
// Peripheral masks (0 pin int, 1 group, 2 timers, 3 rtc, 4 wdt, 5 bod,
// 6 usb0, 7 usb1, 8 serial, 9 serial 3, 10 cmp, 11 plu, 12 os timer, 13 utick)
// ****************************************************************
`define PM_NUM_PERIPH 14
`define PM_MASK_ALL 14'h3fff
`define PM_MASK_DS_KEEP 14'h37fc
`define PM_MASK_DS_WAKE 14'h3fff
`define PM_MASK_PD_KEEP 14'h1608
`define PM_MASK_PD_WAKE 14'h160a
`define PM_MASK_RTC 14'h0008
`define PM_MASK_OST 14'h1000
`define PM_MASK_BOD 14'h0020

// ****************************************************************
// Retention and power domains
// ****************************************************************
`define PM_RET_ALL 7'h7f
`define PM_RET_PDOWN 7'h3f
`define PM_RET_RTC 7'h08
`define PM_RET_OST 7'h10
`define PM_DOM_ALL 5'h1f
`define PM_DOM_DPD 5'h0e
`define PM_DOM_OST 5'h10

// ****************************************************************
// Reference selection codes and frequency limits in Hz
// ****************************************************************
`define PM_REF_OSC12 2'h0
`define PM_REF_XTAL 2'h1
`define PM_REF_LP1M 2'h2
`define PM_REF_RTC32K 2'h3
`define PM_OSC12_HZ 28'h0b71b00
`define PM_LP1M_HZ 28'h00f4240
`define PM_RTC32K_HZ 28'h0008000
`define PM_PLL_IN_MIN_HZ 28'h00007d0
`define PM_PLL_IN_MAX_HZ 28'h8f0d180
`define PM_PLL_OUT_MIN_HZ 40'h0000124f80
`define PM_PLL_OUT_MAX_HZ 40'h0008f0d180

// ****************************************************************
// Timing
// ****************************************************************
`define PM_CLK_HZ 20000000
`define PM_RESTORE_NS 10000
`define PM_RESTORE_CYC ((`PM_RESTORE_NS * (`PM_CLK_HZ / 1000000) + 999) / 1000)
`define PM_HALT_NS 200
`define PM_HALT_CYC ((`PM_HALT_NS * (`PM_CLK_HZ / 1000000) + 999) / 1000)

`endif

// File: pm_pkg.sv
// Types shared by the power-mode controller and its clock switch.
// Assumes the constants of pm_map.svh are included where needed.
package pm_pkg;

  // ****************************************************************
  // Modes and states
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'h0,
    MODE_SLEEP = 3'h1,
    MODE_DSLEEP = 3'h2,
    MODE_PDOWN = 3'h3,
    MODE_DPDOWN = 3'h4
  } pm_mode_t;

  typedef enum logic [5:0] {
    ST_ACTIVE = 6'h01,
    ST_SLEEP = 6'h02,
    ST_DSLEEP = 6'h04,
    ST_PDOWN = 6'h08,
    ST_DPDOWN = 6'h10,
    ST_WAKE = 6'h20
  } pm_state_t;

  typedef enum logic [2:0] {
    SW_IDLE = 3'h1,
    SW_HALT = 3'h2,
    SW_RESTART = 3'h4
  } sw_state_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic en;
    logic [1:0] ref_sel;
    logic [11:0] mult;
  } pll_cfg_t;

  typedef struct packed {
    logic [4:0] thresh;
    logic reset_sel;
  } bod_cfg_t;

  typedef struct packed {
    logic [1:0] cpu_clk_en;
    logic flash_pwr;
    logic dcdc_en;
    logic gpio_hold;
    logic gpio_low;
    logic pin_tristate;
    logic cpu0_ret;
  } pwr_ctrl_t;

endpackage : pm_pkg

// File: clk_switch.sv
// Clock multiplexer select sequencer, synchronized or divider-halting.
// Assumes src_run bit 0 is the tied-off none input and is always reported running.
`timescale 1ns/10ps
`include "pm_map.svh"
module clk_switch
  import pm_pkg::*;
#(
  parameter int SW = 3,
  parameter bit SYNC = 1'b1,
  parameter int HALT_CYC = `PM_HALT_CYC
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [SW-1:0] req_sel,
  input wire logic [2**SW-1:0] src_run,
  output logic [SW-1:0] cur_sel,
  output logic div_run,
  output logic blocked
);

  sw_state_t state_reg;
  logic [SW-1:0] hold_reg;
  logic [7:0] cnt_reg;
  logic both_run;

  // Both the old and the new source must be toggling for a clean handover.
  assign both_run = src_run[req_sel] & src_run[cur_sel];

  // ****************************************************************
  // Select sequencing
  // ****************************************************************
  // A synchronized mux waits for both clocks; the other kind stops the divider first.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= SW_IDLE;
      cur_sel <= '0;
      hold_reg <= '0;
      cnt_reg <= 8'h00;
      div_run <= 1'b1;
      blocked <= 1'b0;
    end
    else
    begin
      case (state_reg)
        SW_IDLE:
        begin
          if (req_sel != cur_sel)
          begin
            if (SYNC)
            begin
              if (both_run)
              begin
                cur_sel <= req_sel;
                blocked <= 1'b0;
              end
              else
              begin
                blocked <= 1'b1;
              end
            end
            else
            begin
              div_run <= 1'b0;
              hold_reg <= req_sel;
              cnt_reg <= 8'h00;
              state_reg <= SW_HALT;
            end
          end
          else
          begin
            blocked <= 1'b0;
          end
        end
        SW_HALT:
        begin
          if (cnt_reg == 8'(HALT_CYC - 1))
          begin
            cur_sel <= hold_reg;
            cnt_reg <= 8'h00;
            state_reg <= SW_RESTART;
          end
          else
          begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        SW_RESTART:
        begin
          if (cnt_reg == 8'(HALT_CYC - 1))
          begin
            div_run <= 1'b1;
            state_reg <= SW_IDLE;
          end
          else
          begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        default:
        begin
          state_reg <= SW_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sync_switch_a: assert property (@(posedge clk) disable iff (reset)
    (SYNC && cur_sel != $past(cur_sel)) |-> $past(both_run))
    else $error("synchronized mux switched without both clocks running");
  div_halt_a: assert property (@(posedge clk) disable iff (reset)
    (!SYNC && cur_sel != $past(cur_sel)) |-> !div_run ##1 !div_run)
    else $error("divider running while unsynchronized mux switched");

endmodule : clk_switch

// File: wake_source_model.sv
// Partner model: RTC oscillator enable and peripheral wake requests.
// Assumes the bench commands it at the falling edge of CLK.
`timescale 1ns/10ps
module wake_source_model
(
  input wire logic clk,
  input wire logic reset,
  input wire logic rtc_req,
  input wire logic [13:0] evt_req,
  output logic rtc_en_reg,
  output logic [13:0] evt_reg
);
  // ************************************************************
  // Software side
  // ************************************************************
  // The RTC oscillator is off until software enables it, so the synchronized main mux must block before then.
  always_ff @(posedge clk)
  begin
    if (reset)
      rtc_en_reg <= 1'b0;
    else
      rtc_en_reg <= rtc_req;
  end

  // Peripherals raise wake requests one cycle after the command, as levels.
  always_ff @(posedge clk)
  begin
    if (reset)
      evt_reg <= 14'h0000;
    else
      evt_reg <= evt_req;
  end
endmodule : wake_source_model

// File: tb.sv
// Self-checking bench for the clock and power-mode controller.
// Assumes RESTORE_CYC is set to 4 to keep the wake phase short.
`timescale 1ns/10ps
module tb;
  import pm_pkg::*;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic ent = 1'b0;
  pm_mode_t mreq = MODE_ACTIVE;
  logic rtc_req = 1'b0;
  logic [13:0] evt_req = 14'h0000;
  logic rtc_en;
  logic [13:0] evt;
  logic alarm = 1'b0;
  logic [2:0] msel = 3'h0;
  logic [4:0] vbat = 5'h14;
  logic clr = 1'b0;
  logic [13:0] keep = 14'h3f0f;
  logic [13:0] wen = 14'h3fff;
  logic [3:0] wpin = 4'h0;
  logic ost = 1'b0;
  logic [3:0] sram = 4'h5;
  pll_cfg_t pla = '0;
  logic [2:0] mon = 3'h0;
  bod_cfg_t bodc = 6'h20;
  logic pa_run;
  logic pa_err;
  logic [2:0] mon_sel;
  logic mon_div;
  logic crst;
  logic [3:0] sbr;
  logic [2:0] sel;
  logic blk;
  logic irq;
  pwr_ctrl_t pc;
  logic [13:0] pce;
  logic [6:0] ret;
  logic [4:0] dom;
  pm_state_t st;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;

  // ************************************************************
  // Clock, partner and design
  // ************************************************************
  initial
  begin
    forever #25 CLK = ~CLK;
  end

  wake_source_model wake_source_model_i (.clk(CLK), .reset(RESET), .rtc_req(rtc_req),
    .evt_req(evt_req), .rtc_en_reg(rtc_en), .evt_reg(evt));

  clock_and_power_mode_control #(.RESTORE_CYC(4)) clock_and_power_mode_control_i (
    .CLK(CLK), .RESET(RESET), .ENTER_REQ(ent), .MODE_REQ(mreq), .PERIPH_KEEP(keep),
    .WAKE_EN(wen), .WAKE_EVT(evt), .WAKE_PIN(wpin), .ONE_HZ_ALARM_FLAG(alarm),
    .OSTIMER_DPD_EN(ost), .SRAM_RET_CFG(sram), .OSC12_RUN(1'b1), .OSC96_RUN(1'b1),
    .XTAL_RUN(1'b1), .LP1M_RUN(1'b1), .RTC_OSC_CONTROL_REG(rtc_en), .PLL_A_CFG(pla),
    .PLL_B_CFG('0), .MAIN_SEL_REQ(msel), .MON_SEL_REQ(mon), .VBAT_LEVEL(vbat),
    .BOD_CFG(bodc), .BOD_IRQ_CLR(clr), .PLL_A_OUTPUT_RUN(pa_run), .PLL_B_OUTPUT_RUN(),
    .PLL_A_CFG_ERR(pa_err), .PLL_B_CFG_ERR(), .MAIN_CLK_SEL(sel), .MAIN_SW_BLOCKED(blk),
    .CLOCK_MONITOR_OUT_SEL(mon_sel), .CLOCK_MONITOR_DIV_RUN(mon_div),
    .BROWNOUT_DETECTOR_IRQ(irq), .CHIP_RESET_REQ(crst), .PWR_CTRL(pc), .PERIPH_CLK_EN(pce),
    .SRAM_BANK_RET(sbr), .REG_RETAIN(ret), .DOMAIN_PWR(dom), .MODE_STATE(st));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // The request is taken at the rising edge between the two falling edges.
  task enter(input pm_mode_t m);
    mreq = m;
    ent = 1'b1;
    @(negedge CLK);
    ent = 1'b0;
  endtask : enter

  // A wake level passes the partner register, then the design's own edge.
  task wake(input int b);
    evt_req[b] = 1'b1;
    repeat (2) @(negedge CLK);
    chk(st, ST_WAKE);
    chk(pc.cpu_clk_en, 2'h0);
    evt_req = 14'h0000;
    repeat (4) @(negedge CLK);
    chk(st, ST_ACTIVE);
    chk(pc.cpu_clk_en, 2'h3);
  endtask : wake

  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_sleep;
    enter(MODE_SLEEP);
    chk(st, ST_SLEEP);
    chk(pce, keep);
    // A request whose wake enable is off must leave the cores stopped.
    wen = 14'h3ffe;
    evt_req[0] = 1'b1;
    repeat (3) @(negedge CLK);
    chk(st, ST_SLEEP);
    evt_req = 14'h0000;
    @(negedge CLK);
    wen = 14'h3fff;
    wake(0);
    $display("sleep done");
  endtask : t_sleep

  task t_dsleep;
    enter(MODE_DSLEEP);
    chk(pce, keep & 14'h37fc);
    chk({pc.flash_pwr, pc.gpio_hold}, 2'h1);
    chk(sbr, 4'h5);
    wake(7);
    $display("deep-sleep done");
  endtask : t_dsleep

  task t_pdown;
    sram = 4'ha;
    enter(MODE_PDOWN);
    chk(sbr, 4'ha);
    chk(pce, keep & 14'h1608);
    chk({pc.dcdc_en, pc.gpio_low, pc.cpu0_ret}, 3'h3);
    chk(ret, 7'h3f);
    evt_req[0] = 1'b1;
    repeat (3) @(negedge CLK);
    chk(st, ST_PDOWN);
    evt_req = 14'h0000;
    wake(12);
    $display("power-down done");
  endtask : t_pdown

  // First pass without the OS timer, woken by the alarm; second with it, woken by a pin.
  task t_dpd;
    for (int k = 0; k < 2; k++)
    begin
      ost = (k == 1);
      enter(MODE_DPDOWN);
      chk(dom, ost ? 5'h1e : 5'h0e);
      chk(pce, ost ? 14'h1008 : 14'h0008);
      chk(ret, ost ? 7'h18 : 7'h08);
      chk(pc.pin_tristate, 1'b1);
      alarm = !ost;
      wpin = ost ? 4'h4 : 4'h0;
      @(negedge CLK);
      chk(st, ST_WAKE);
      alarm = 1'b0;
      wpin = 4'h0;
      repeat (4) @(negedge CLK);
      chk(st, ST_ACTIVE);
    end
    $display("deep power-down done");
  endtask : t_dpd

  // Switching to a stopped RTC clock must wait until software enables it.
  task t_mux;
    msel = 3'h5;
    repeat (2) @(negedge CLK);
    chk(blk, 1'b1);
    chk(sel, 3'h0);
    rtc_req = 1'b1;
    repeat (3) @(negedge CLK);
    chk(sel, 3'h5);
    chk(blk, 1'b0);
    $display("mux done");
  endtask : t_mux

  // Runs after the RTC oscillator is enabled, so the 32 kHz reference counts as running.
  task t_pll;
    pla = {1'b1, 2'h0, 12'h00a};
    @(negedge CLK);
    chk({pa_run, pa_err}, 2'h2);
    pla.mult = 12'h00d;
    @(negedge CLK);
    chk({pa_run, pa_err}, 2'h1);
    pla = {1'b1, 2'h3, 12'h040};
    @(negedge CLK);
    chk({pa_run, pa_err}, 2'h2);
    pla.en = 1'b0;
    @(negedge CLK);
    chk({pa_run, pa_err}, 2'h0);
    $display("pll done");
  endtask : t_pll

  // The divider stops, the select moves four cycles later, the divider restarts after four more.
  task t_mon;
    mon = 3'h2;
    @(negedge CLK);
    chk({mon_div, mon_sel}, 4'h0);
    repeat (4) @(negedge CLK);
    chk({mon_div, mon_sel}, 4'h2);
    repeat (4) @(negedge CLK);
    chk(mon_div, 1'b1);
    mon = 3'h0;
    repeat (9) @(negedge CLK);
    chk({mon_div, mon_sel}, 4'h8);
    $display("monitor mux done");
  endtask : t_mon

  // A clear in the same cycle as a new brown-out loses; the reset choice raises no interrupt.
  task t_bod;
    vbat = 5'h0a;
    clr = 1'b1;
    @(negedge CLK);
    chk(irq, 1'b1);
    vbat = 5'h14;
    @(negedge CLK);
    clr = 1'b0;
    chk(irq, 1'b0);
    bodc.reset_sel = 1'b1;
    vbat = 5'h0a;
    @(negedge CLK);
    chk({crst, irq}, 2'h2);
    vbat = 5'h14;
    @(negedge CLK);
    chk(crst, 1'b0);
    bodc.reset_sel = 1'b0;
    $display("brown-out done");
  endtask : t_bod

  task results;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // A hang is cut short well beyond the fewer than a hundred cycles the tests need.
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      results();
    end
  end

  initial
  begin
    repeat (16) @(negedge CLK);
    RESET = 1'b0;
    chk(st, ST_ACTIVE);
    chk(ret, 7'h7f);
    t_sleep();
    t_dsleep();
    t_pdown();
    t_dpd();
    t_mux();
    t_pll();
    t_mon();
    t_bod();
    results();
  end
endmodule : tb
